// ===== design/flash_self_program_ctrl.sv
// flash self-programming control with wishbone register access
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_ctrl
  import selfprog_pkg::*;
#(
  parameter int  PAGE_WORDS   = 32,
  parameter int  PAGE_BITS    = 10,
  parameter bit  HAS_RWW      = 1'b1,
  parameter int  PROG_TICKS   = PROG_CYCLES,
  parameter logic [15:0] STALLING_SECTION_START = 16'h7000,
  parameter logic [7:0] LOCK_BITS  = 8'hff,
  parameter logic [7:0] FUSE_LOW   = 8'h62,
  parameter logic [7:0] FUSE_HIGH  = 8'hd9,
  parameter logic [7:0] FUSE_EXT   = 8'hff
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // core side status
  input  wire logic        globalIrqEnable,
  input  wire logic        eeprom_write_busy,
  input  wire logic        fetchInBoot,
  // flash macro side
  output logic             flashErase,
  output logic             flashWrite,
  output logic [15:0]      flashPageAddr,
  output logic [15:0]      bufferWord,
  // core control
  output logic             cpuHalt,
  output logic             readyIrq
);
  localparam int PIDX = $clog2(PAGE_WORDS);
  localparam logic [22:0] TICKS = 23'(PROG_TICKS);

  op_state_t   state;
  op_state_t   next_state;
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [2:0]  window;
  logic [2:0]  next_window;
  logic [22:0] timer;
  logic [22:0] next_timer;
  logic        busy;
  logic        next_busy;
  logic        halt;
  logic        next_halt;
  logic [15:0] ptr;
  logic [15:0] next_ptr;
  logic [15:0] data;
  logic [15:0] next_data;
  logic [7:0]  result;
  logic [7:0]  next_result;
  logic        ack;
  logic        next_ack;
  logic [31:0] next_rdata;
  logic [15:0] pageBuf [PAGE_WORDS];
  logic        fill;
  logic        bufClear;
  logic        eeSync1;
  logic        eeSync2;
  logic        irqSync1;
  logic        irqSync2;
  logic        next_eeSync1;
  logic        next_eeSync2;
  logic        next_irqSync1;
  logic        next_irqSync2;
  logic        next_flashErase;
  logic        next_flashWrite;
  logic [15:0] next_flashPageAddr;
  logic [15:0] next_bufferWord;
  logic        next_readyIrq;
  logic [PIDX-1:0] bufIdx;

  logic        wbReq;
  logic        wbWr;
  logic [7:0]  idx;
  logic        storeStb;
  logic        loadStb;
  logic [4:0]  cmd;
  logic        cmdLegal;

  assign wbReq = wb_cyc_i && wb_stb_i && !ack;
  assign wbWr  = wbReq && wb_we_i && wb_sel_i[0];
  assign idx   = wb_adr_i[9:2];
  assign storeStb = wbWr && idx == STROBE_IDX && wb_dat_i[STB_STORE];
  assign loadStb  = wbWr && idx == STROBE_IDX && wb_dat_i[STB_LOAD];
  assign cmd      = wb_dat_i[4:0];
  assign cmdLegal = cmd == CMD_RWW_EN || cmd == CMD_LOCK_RD ||
                    cmd == CMD_PG_WRITE || cmd == CMD_PG_ERASE ||
                    cmd == CMD_FILL;

  // both levels come from outside this clock domain
  always_comb
  begin
    next_eeSync1  = eeprom_write_busy;
    next_eeSync2  = eeSync1;
    next_irqSync1 = globalIrqEnable;
    next_irqSync2 = irqSync1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      eeSync1  <= 1'b0;
      eeSync2  <= 1'b0;
      irqSync1 <= 1'b0;
      irqSync2 <= 1'b0;
    end
    else
    begin
      eeSync1  <= next_eeSync1;
      eeSync2  <= next_eeSync2;
      irqSync1 <= next_irqSync1;
      irqSync2 <= next_irqSync2;
    end
  end

  always_comb
  begin
    next_state  = state;
    next_ctrl   = ctrl;
    next_window = window;
    next_timer  = timer;
    next_busy   = busy;
    next_halt   = halt;
    next_ptr    = ptr;
    next_data   = data;
    next_result = result;
    fill        = 1'b0;
    bufClear    = 1'b0;
    if (wbWr && idx == PTR_IDX)
      next_ptr = wb_dat_i[15:0];
    if (wbWr && idx == DATA_IDX)
      next_data = wb_dat_i[15:0];
    if (wbWr && idx == CTRL_STATUS_IDX)
      next_ctrl[BIT_IRQ_EN] = wb_dat_i[BIT_IRQ_EN];
    unique case (state)
      IDLE:
      begin
        // eeprom write blocks arming; window starts at write
        if (wbWr && idx == CTRL_STATUS_IDX && cmdLegal && !eeSync2)
        begin
          next_ctrl[4:0] = cmd;
          next_window    = STORE_WINDOW;
          next_state     = ARMED;
        end
      end
      ARMED:
      begin
        next_window = window - 3'h1;
        // a new write restarts the window
        if (wbWr && idx == CTRL_STATUS_IDX && cmdLegal && !eeSync2)
        begin
          next_ctrl[4:0] = cmd;
          next_window    = STORE_WINDOW;
        end
        else if (loadStb && ctrl[4:0] == CMD_LOCK_RD &&
                 window > STORE_WINDOW - LOAD_WINDOW && !eeSync2)
        begin
          // readback chosen by pointer, raw fuse polarity
          unique case (ptr[1:0])
            SEL_FUSE_LOW:  next_result = FUSE_LOW;
            SEL_LOCK:      next_result = LOCK_BITS;
            SEL_FUSE_EXT:  next_result = FUSE_EXT;
            SEL_FUSE_HIGH: next_result = FUSE_HIGH;
          endcase
          next_ctrl[4:0] = 5'h00;
          next_state     = IDLE;
        end
        else if (storeStb && !eeSync2)
        begin
          // enable clears after the store completes
          next_ctrl[4:0] = 5'h00;
          next_state     = IDLE;
          unique case (ctrl[4:0])
            // fill buffer word, pointer lsb ignored
            CMD_FILL: fill = 1'b1;
            CMD_RWW_EN:
            begin
              bufClear  = 1'b1;
              next_busy = 1'b0;
            end
            CMD_PG_WRITE, CMD_PG_ERASE:
            begin
              // only boot-section code may program, any page
              if (fetchInBoot)
              begin
                next_ctrl[4:0] = ctrl[4:0];
                next_timer     = TICKS;
                next_state     = PROGRAM;
                next_halt = ptr >= STALLING_SECTION_START || !HAS_RWW;
                next_busy = ptr < STALLING_SECTION_START && HAS_RWW;
              end
            end
            default: ;
          endcase
        end
        else if (window == 3'h1)
        begin
          next_ctrl[4:0] = 5'h00;
          next_state     = IDLE;
        end
      end
      PROGRAM:
      begin
        next_timer = timer - 23'h1;
        if (timer == 23'h1)
        begin
          // bits clear and halt lifts at completion
          next_ctrl[4:0] = 5'h00;
          next_halt      = 1'b0;
          next_state     = IDLE;
        end
      end
      default: next_state = IDLE;
    endcase
  end

  // read data registered so it stands in the ack cycle
  always_comb
  begin
    next_rdata = 32'h0;
    next_ack   = wbReq;
    if (wbReq && !wb_we_i)
    begin
      unique case (idx)
        CTRL_STATUS_IDX:
        begin
          next_rdata[7:0] = ctrl;
          next_rdata[BIT_BUSY] = busy && HAS_RWW;
          next_rdata[BIT_RSVD] = 1'b0;
        end
        PTR_IDX:    next_rdata[15:0] = ptr;
        DATA_IDX:   next_rdata[15:0] = data;
        RESULT_IDX: next_rdata[7:0]  = result;
        default:    next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state    <= IDLE;
      ctrl     <= CTRL_RESET;
      window   <= 3'h0;
      timer    <= 23'h0;
      busy     <= 1'b0;
      halt     <= 1'b0;
      ptr      <= 16'h0;
      data     <= 16'h0;
      result   <= 8'h0;
      ack      <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      state    <= next_state;
      ctrl     <= next_ctrl;
      window   <= next_window;
      timer    <= next_timer;
      busy     <= next_busy;
      halt     <= next_halt;
      ptr      <= next_ptr;
      data     <= next_data;
      result   <= next_result;
      ack      <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end

  // buffer has no reset; cleared explicitly by the re-enable command
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < PAGE_WORDS; i++)
    begin
      if (bufClear)
        pageBuf[i] <= 16'hffff;
      else if (fill && ptr[PIDX:1] == PIDX'(i))
        pageBuf[i] <= data;
    end
  end

  // outputs from flops, fed by next values so they keep state timing
  always_comb
  begin
    bufIdx             = next_ptr[PIDX:1];
    next_flashErase    = next_state == PROGRAM && next_ctrl[BIT_PG_ERASE];
    next_flashWrite    = next_state == PROGRAM && next_ctrl[BIT_PG_WRITE];
    next_flashPageAddr = next_ptr & ~16'(2 * PAGE_WORDS - 1);
    next_bufferWord    = pageBuf[bufIdx];
    // a buffer update in this cycle must show through at once
    if (bufClear)
      next_bufferWord = 16'hffff;
    else if (fill && ptr[PIDX:1] == bufIdx)
      next_bufferWord = data;
    next_readyIrq = next_ctrl[BIT_IRQ_EN] && next_irqSync2 &&
                    !next_ctrl[BIT_ENABLE] && !next_eeSync2 &&
                    next_state != PROGRAM;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      flashErase    <= 1'b0;
      flashWrite    <= 1'b0;
      flashPageAddr <= 16'h0;
      bufferWord    <= 16'h0;
      readyIrq      <= 1'b0;
    end
    else
    begin
      flashErase    <= next_flashErase;
      flashWrite    <= next_flashWrite;
      flashPageAddr <= next_flashPageAddr;
      bufferWord    <= next_bufferWord;
      readyIrq      <= next_readyIrq;
    end
  end

  assign wb_ack_o      = ack;
  assign cpuHalt       = halt;
endmodule : flash_self_program_ctrl
`default_nettype wire

// ===== design/selfprog_pkg.sv
// constants for the flash self-programming control block
package selfprog_pkg;
  // register map (word index, byte address is four times the index)
  localparam logic [7:0] CTRL_STATUS_IDX  = 8'h37;
  localparam logic [7:0] PTR_IDX          = 8'h38;
  localparam logic [7:0] DATA_IDX         = 8'h39;
  localparam logic [7:0] RESULT_IDX       = 8'h3a;
  localparam logic [7:0] STROBE_IDX       = 8'h3b;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  // control and status bit positions
  localparam int BIT_IRQ_EN   = 7;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_RSVD     = 5;
  localparam int BIT_RWW_EN   = 4;
  localparam int BIT_LOCK_RD  = 3;
  localparam int BIT_PG_WRITE = 2;
  localparam int BIT_PG_ERASE = 1;
  localparam int BIT_ENABLE   = 0;
  // accepted lower five-bit command patterns
  localparam logic [4:0] CMD_RWW_EN   = 5'h11;
  localparam logic [4:0] CMD_LOCK_RD  = 5'h09;
  localparam logic [4:0] CMD_PG_WRITE = 5'h05;
  localparam logic [4:0] CMD_PG_ERASE = 5'h03;
  localparam logic [4:0] CMD_FILL     = 5'h01;
  // window lengths in cycles
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;
  // readback pointer selections
  localparam logic [1:0] SEL_FUSE_LOW  = 2'h0;
  localparam logic [1:0] SEL_LOCK      = 2'h1;
  localparam logic [1:0] SEL_FUSE_EXT  = 2'h2;
  localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
  // strobe register bits
  localparam int STB_STORE = 0;
  localparam int STB_LOAD  = 1;
  // programming time
  localparam int  CLK_MHZ      = 125;
  localparam int  PROG_TIME_US = 3700;
  localparam int  PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {IDLE, ARMED, PROGRAM} op_state_t;
endpackage : selfprog_pkg

// ===== dv/cpu_core_model.sv
// boot loader core model: wishbone master plus core status
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  // clock
  input  wire logic        core_clk,
  // wishbone master
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [9:0]       adr,
  output logic [31:0]      wdat,
  input  wire logic [31:0] rdat,
  input  wire logic        ack,
  // core status
  output logic             irqFlag,
  output logic             eeBusy,
  output logic             inBoot
);
  initial {cyc, stb, we, adr, wdat, irqFlag, eeBusy, inBoot} = '0;
  // only register traffic, never the busy section
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
endmodule : cpu_core_model
`default_nettype wire

// ===== dv/flash_self_program_ctrl_asserts.sv
// port checker for the flash self-programming control
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_ctrl_asserts #(
  parameter logic [15:0] STALLING_SECTION_START = 16'h7000
) (
  // bus side
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // core and flash side
  input wire logic        globalIrqEnable,
  input wire logic        eeprom_write_busy,
  input wire logic        fetchInBoot,
  input wire logic        flashErase,
  input wire logic        flashWrite,
  input wire logic [15:0] flashPageAddr,
  input wire logic [15:0] bufferWord,
  input wire logic        cpuHalt,
  input wire logic        readyIrq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic prog;
  logic rdCtrl;
  assign prog = flashErase || flashWrite;
  assign rdCtrl = wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h37;
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  AST_RSVD_ZERO: assert property (rdCtrl |-> wb_dat_o[5] == 1'b0)
    else $error("reserved bit set");
  AST_IRQ_QUIET: assert property (prog |-> !readyIrq)
    else $error("irq during programming");
  AST_ONE_OP: assert property (!(flashErase && flashWrite))
    else $error("erase and write together");
  AST_MIN_LEN: assert property ($rose(prog) |=> prog [*8])
    else $error("programming cut short");
  AST_BOOT_ONLY: assert property ($rose(prog) |-> $past(fetchInBoot))
    else $error("programming from app section");
  AST_HALT_STALLING_SECTION: assert property ($rose(prog) && flashPageAddr >= STALLING_SECTION_START
    |-> ##[0:1] cpuHalt)
    else $error("no halt on stalling section");
  AST_NO_HALT_RWW: assert property ($rose(prog) && flashPageAddr < STALLING_SECTION_START
    |=> !cpuHalt)
    else $error("halt on concurrent section");
  AST_HALT_END: assert property (cpuHalt |-> prog || $past(prog))
    else $error("halt outside programming");
  COV_ERASE: cover property ($rose(flashErase));
  COV_WRITE: cover property ($rose(flashWrite));
  COV_IRQ: cover property ($rose(readyIrq));
endmodule : flash_self_program_ctrl_asserts
bind flash_self_program_ctrl flash_self_program_ctrl_asserts
  #(.STALLING_SECTION_START(STALLING_SECTION_START)) u_chk (.*);
`default_nettype wire

// ===== dv/flash_self_program_ctrl_tb.sv
// self-checking bench for the flash self-programming control
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_ctrl_tb;
  import selfprog_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc, stb, we, ack, irqF, eeB, inB, erase, write, halt, irq;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat, q, d, seed = 32'h38;
  logic [15:0] page, bufWord;
  int          errorCnt = 0;
  int          compares = 0;
  always #4 core_clk = ~core_clk;
  cpu_core_model u_cpu_core_model (.core_clk(core_clk), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .wdat(wdat), .rdat(rdat), .ack(ack),
    .irqFlag(irqF), .eeBusy(eeB), .inBoot(inB));
  flash_self_program_ctrl #(.PROG_TICKS(20)) u_flash_self_program_ctrl (
    .core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .globalIrqEnable(irqF),
    .eeprom_write_busy(eeB), .fetchInBoot(inB), .flashErase(erase),
    .flashWrite(write), .flashPageAddr(page), .bufferWord(bufWord),
    .cpuHalt(halt), .readyIrq(irq));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // pointer 0 low, 1 lock, 2 extended, 3 high
  function automatic logic [31:0] fuse(input int p);
    logic [7:0] t[4] = '{8'h62, 8'hff, 8'hff, 8'hd9};
    return {24'h0, t[p]};
  endfunction : fuse
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    logic [31:0] x;
    u_cpu_core_model.xfer(1'b1, i, v, x);
  endtask : wr
  task automatic rd(input logic [7:0] i);
    u_cpu_core_model.xfer(1'b0, i, 32'h0, q);
  endtask : rd
  task automatic cmd(input logic [7:0] c, input logic [1:0] s);
    wr(CTRL_STATUS_IDX, {24'h0, c});
    wr(STROBE_IDX, {30'h0, s});
    @(posedge core_clk);
  endtask : cmd
  // halted core waits for the operation to end
  task automatic waitDone();
    for (int i = 0; i < 60 && (erase || write); i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
  endtask : waitDone
  task automatic results();
    $display("errors %0d compares %0d", errorCnt, compares);
    if (errorCnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errorCnt++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    u_cpu_core_model.irqFlag <= 1'b1;
    u_cpu_core_model.inBoot <= 1'b1;
    rd(CTRL_STATUS_IDX); chk(q, 32'h0);
    wr(CTRL_STATUS_IDX, 32'h3f);
    wr(CTRL_STATUS_IDX, 32'h07);
    rd(CTRL_STATUS_IDX); chk(q, 32'h0);
    rd(8'h3c); chk(q, 32'h0);
    for (int p = 0; p < 4; p++)
    begin
      wr(PTR_IDX, p);
      cmd(8'h09, 2'h2);
      rd(RESULT_IDX); chk(q, fuse(p));
    end
    repeat (3)
    begin
      d = rnd();
      wr(PTR_IDX, {16'h0, d[31:16]});
      wr(DATA_IDX, {16'h0, d[15:0]});
      cmd(8'h01, 2'h1); chk(32'(bufWord), {16'h0, d[15:0]});
    end
    cmd(8'h11, 2'h1); chk(32'(bufWord), 32'hffff);
    wr(PTR_IDX, 32'h7040);
    cmd(8'h03, 2'h1); chk({erase, halt}, 2'b11);
    chk(32'(page), 32'h7040);
    waitDone();
    rd(CTRL_STATUS_IDX); chk(q, 32'h0);
    u_cpu_core_model.inBoot <= 1'b0;
    cmd(8'h03, 2'h1); chk(erase, 1'b0);
    u_cpu_core_model.inBoot <= 1'b1;
    wr(CTRL_STATUS_IDX, 32'h05);
    repeat (5) @(posedge core_clk);
    wr(STROBE_IDX, 32'h1);
    @(posedge core_clk); chk(write, 1'b0);
    wr(PTR_IDX, 32'h0080);
    cmd(8'h85, 2'h1); chk({write, halt, irq}, 3'b100);
    rd(CTRL_STATUS_IDX); chk(q, 32'hc5);
    waitDone();
    rd(CTRL_STATUS_IDX); chk(q, 32'hc0);
    chk(irq, 1'b1);
    cmd(8'h91, 2'h1);
    rd(CTRL_STATUS_IDX); chk(q, 32'h80);
    u_cpu_core_model.eeBusy <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0);
    cmd(8'h89, 2'h2);
    rd(CTRL_STATUS_IDX); chk(q & 32'h1f, 32'h0);
    results();
  end
endmodule : flash_self_program_ctrl_tb
`default_nettype wire
